// ---- verilog/option_card_io.sv ----
// Pulse and alarm outputs, counting and sync inputs, analog clamp and hold for the option cards.
`timescale 1ns/1ns
// Notes on behaviour
// - One shared pulse width: 30 or 50..500ms.
// - Per-output weight: 1,10,100,1k,10k,100k units.
// - Contact open when idle, closed during pulse.
// - Pulses counted from one selected energy quantity.
// - Pulse timing resolved to whole milliseconds.
// - Each output independently alarm or pulsed.
// - Alarm asserts after threshold exceeded beyond time-lag.
// - Alarm clears on crossing back with hysteresis.
// - Forced output level released after 10 minutes.
// - Each input independently counting or synchronising.
// - Counting input adds pulse times weight.
// - Weight 0.0001 to 999.9999, four decimals kept.
// - Input counter loadable with any value.
// - Sync pulse rounds clock within 5 seconds.
// - Input logic levels readable as status.
// - Analog output follows one linear slope.
// - Analog output saturates at min and max.
// - Analog hold within range, released after 10 minutes.
// - Mixed card: one input, one output only.
// - Serial port or network port, never both.
module option_card_io import io_card_pkg::*; #(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF,
	parameter int HOLD_TIMEOUT_MS = HOLD_TIMEOUT_MS_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_mixed_card,
	input wire logic i_net_port_sel,
	input wire logic [3:0] i_pulse_width_sel,
	input wire logic [N_ENERGY-1:0] i_energy_tick,
	input wire logic [N_CH-1:0] i_out_pulse_mode,
	input wire logic [N_CH*3-1:0] i_energy_sel,
	input wire logic [N_CH*3-1:0] i_weight_code,
	input wire logic [N_CH*16-1:0] i_alarm_value,
	input wire logic [N_CH*16-1:0] i_alarm_thr,
	input wire logic [N_CH-1:0] i_alarm_upper,
	input wire logic [N_CH*16-1:0] i_alarm_lag_ms,
	input wire logic [N_CH-1:0] i_force_cmd,
	input wire logic [N_CH-1:0] i_force_level,
	input wire logic [N_CH-1:0] i_din,
	input wire logic [N_CH-1:0] i_in_sync_mode,
	input wire logic [N_CH*24-1:0] i_in_weight,
	input wire logic [N_CH-1:0] i_cnt_load,
	input wire logic [N_CH*48-1:0] i_cnt_load_val,
	input wire logic [11:0] i_clk_sec_of_hour,
	input wire logic [N_CH*16-1:0] i_ana_var,
	input wire logic [N_CH*16-1:0] i_ana_in_min,
	input wire logic [N_CH*16-1:0] i_ana_gain,
	input wire logic [N_CH*16-1:0] i_ana_out_min,
	input wire logic [N_CH*16-1:0] i_ana_out_max,
	input wire logic [N_CH-1:0] i_ana_hold_cmd,
	input wire logic [N_CH*16-1:0] i_ana_hold_val,
	output logic [N_CH-1:0] o_relay_close,
	output logic [N_CH-1:0] o_force_active,
	output logic [N_CH-1:0] o_alarm_active,
	output logic [N_CH*48-1:0] o_in_count,
	output logic [N_CH-1:0] o_din_level,
	output logic o_clk_round,
	output logic o_clk_round_up,
	output logic [N_CH*16-1:0] o_ana_out,
	output logic [N_CH-1:0] o_ana_hold_active,
	output logic o_serial_en,
	output logic o_net_en
);
	// ------------------------------------------------------------
	// Reset release and millisecond time base
	// ------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rstn;
	logic [14:0] ms_cnt_reg, ms_cnt_next;
	logic ms_tick;
	logic [8:0] pulse_ms;

	// Reset asserts at once and is released after two clock edges.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rstn = rst_sync_reg[1];

	// Millisecond tick keeps every pulse edge on a whole millisecond.
	assign ms_tick = (ms_cnt_reg == 15'(CYC_PER_MS - 1));
	always_comb begin
		ms_cnt_next = ms_tick ? 15'h0 : ms_cnt_reg + 15'h1;
	end
	always_ff @(posedge i_ref_clk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_reg <= 15'h0;
		end else if (i_ce) begin
			ms_cnt_reg <= ms_cnt_next;
		end
	end

	// Shared pulse width: code 0 is the short width, codes 1..10 step by 50 ms.
	always_comb begin
		if (i_pulse_width_sel == 4'h0) begin
			pulse_ms = PW_SHORT_MS;
		end else if (i_pulse_width_sel > PW_MAX_CODE) begin
			pulse_ms = 9'(PW_STEP_MS * PW_MAX_CODE);
		end else begin
			pulse_ms = 9'(PW_STEP_MS * i_pulse_width_sel);
		end
	end

	// Exactly one communication port is enabled.
	assign o_serial_en = ~i_net_port_sel;
	assign o_net_en = i_net_port_sel;

	// Weight code to energy units per pulse.
	function automatic logic [16:0] weight_units(input logic [2:0] code);
		case (code)
			3'h0: weight_units = 17'd1;
			3'h1: weight_units = 17'd10;
			3'h2: weight_units = 17'd100;
			3'h3: weight_units = 17'd1000;
			3'h4: weight_units = 17'd10000;
			default: weight_units = 17'd100000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Sync pulse rounding of the internal clock
	// ------------------------------------------------------------
	logic [N_CH-1:0] din_meta_reg, din_sync_reg, din_prev_reg;
	logic [N_CH-1:0] din_rise;
	logic round_reg, round_next, round_up_reg, round_up_next;
	logic sync_hit;

	// Input pins pass two flip-flops; the edge detector compares the second with a third.
	always_ff @(posedge i_ref_clk or negedge rstn) begin
		if (!rstn) begin
			din_meta_reg <= '0;
			din_sync_reg <= '0;
			din_prev_reg <= '0;
		end else if (i_ce) begin
			din_meta_reg <= i_din;
			din_sync_reg <= din_meta_reg;
			din_prev_reg <= din_sync_reg;
		end
	end
	assign din_rise = din_sync_reg & ~din_prev_reg;
	assign o_din_level = din_sync_reg;

	// A sync pulse zeroes minutes and seconds only near the hour.
	always_comb begin
		sync_hit = |(din_rise & i_in_sync_mode & {~i_mixed_card, 1'b1});
		round_next = 1'b0;
		round_up_next = 1'b0;
		if (sync_hit && i_clk_sec_of_hour < SYNC_WINDOW_S) begin
			round_next = 1'b1;
		end else if (sync_hit && i_clk_sec_of_hour > SEC_PER_HOUR - SYNC_WINDOW_S) begin
			round_next = 1'b1;
			round_up_next = 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk or negedge rstn) begin
		if (!rstn) begin
			round_reg <= 1'b0;
			round_up_reg <= 1'b0;
		end else if (i_ce) begin
			round_reg <= round_next;
			round_up_reg <= round_up_next;
		end
	end
	assign o_clk_round = round_reg;
	assign o_clk_round_up = round_up_reg;

	// ------------------------------------------------------------
	// Per-channel outputs, inputs and analog outputs
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < N_CH; ch++) begin : g_ch
			logic ch_en;
			logic [16:0] acc_reg, acc_next;
			logic [7:0] pend_reg, pend_next;
			pulse_state_t ps_reg, ps_next;
			logic [8:0] pw_cnt_reg, pw_cnt_next;
			logic [15:0] lag_cnt_reg, lag_cnt_next;
			logic alarm_reg, alarm_next, beyond, back;
			logic [19:0] force_cnt_reg, force_cnt_next;
			logic force_reg, force_next, force_lvl_reg, force_lvl_next;
			logic relay_reg, relay_next;
			logic [47:0] cnt_reg, cnt_next;
			logic [19:0] hold_cnt_reg, hold_cnt_next;
			logic hold_reg, hold_next;
			logic [15:0] hold_val_reg, hold_val_next, ana_reg, ana_next;
			logic [15:0] v, thr, omin, omax, hval;
			logic [31:0] prod;
			logic [24:0] lin;
			logic etick, earned;

			// The second channel's relay and counting input are disabled on the mixed card.
			assign ch_en = (ch == 0) || !i_mixed_card;
			assign v = i_alarm_value[ch*16 +: 16];
			assign thr = i_alarm_thr[ch*16 +: 16];
			assign etick = (i_energy_sel[ch*3 +: 3] < 3'(N_ENERGY))
				&& i_energy_tick[i_energy_sel[ch*3 +: 3]];
			assign earned = etick && (acc_reg + 17'h1 >=
				weight_units(i_weight_code[ch*3 +: 3]));

			// Energy accumulation, pulse queue and pulse emitter.
			always_comb begin
				acc_next = acc_reg;
				pend_next = pend_reg;
				ps_next = ps_reg;
				pw_cnt_next = pw_cnt_reg;
				if (etick) begin
					acc_next = earned ? 17'h0 : acc_reg + 17'h1;
				end
				if (earned && pend_reg != PEND_MAX) begin
					pend_next = pend_reg + 8'h1;
				end
				if (ms_tick) begin
					case (ps_reg)
						PS_IDLE: begin
							if (pend_next != 8'h0) begin
								pend_next = pend_next - 8'h1;
								ps_next = PS_ON;
								pw_cnt_next = pulse_ms - 9'h1;
							end
						end
						PS_ON: begin
							if (pw_cnt_reg == 9'h0) begin
								ps_next = PS_GAP;
								pw_cnt_next = pulse_ms - 9'h1;
							end else begin
								pw_cnt_next = pw_cnt_reg - 9'h1;
							end
						end
						PS_GAP: begin
							if (pw_cnt_reg == 9'h0) begin
								ps_next = PS_IDLE;
							end else begin
								pw_cnt_next = pw_cnt_reg - 9'h1;
							end
						end
						default: ps_next = PS_IDLE;
					endcase
				end
			end

			// Alarm with time-lag on entry and hysteresis on exit.
			always_comb begin
				beyond = i_alarm_upper[ch] ? (v > thr) : (v < thr);
				back = i_alarm_upper[ch] ? ({1'b0, v} + 17'(ALARM_HYST) < {1'b0, thr})
					: ({1'b0, v} > {1'b0, thr} + 17'(ALARM_HYST));
				alarm_next = alarm_reg;
				lag_cnt_next = lag_cnt_reg;
				if (alarm_reg) begin
					lag_cnt_next = 16'h0;
					if (back) begin
						alarm_next = 1'b0;
					end
				end else if (!beyond) begin
					lag_cnt_next = 16'h0;
				end else if (ms_tick) begin
					if (lag_cnt_reg >= i_alarm_lag_ms[ch*16 +: 16]) begin
						alarm_next = 1'b1;
					end else begin
						lag_cnt_next = lag_cnt_reg + 16'h1;
					end
				end
			end

			// Forced level with automatic release; relay choice per mode.
			always_comb begin
				force_next = force_reg;
				force_lvl_next = force_lvl_reg;
				force_cnt_next = force_cnt_reg;
				if (i_force_cmd[ch]) begin
					force_next = 1'b1;
					force_lvl_next = i_force_level[ch];
					force_cnt_next = 20'(HOLD_TIMEOUT_MS - 1);
				end else if (force_reg && ms_tick) begin
					if (force_cnt_reg == 20'h0) begin
						force_next = 1'b0;
					end else begin
						force_cnt_next = force_cnt_reg - 20'h1;
					end
				end
				if (!ch_en) begin
					relay_next = 1'b0;
				end else if (force_reg) begin
					relay_next = force_lvl_reg;
				end else if (i_out_pulse_mode[ch]) begin
					relay_next = (ps_reg == PS_ON);
				end else begin
					relay_next = alarm_reg;
				end
			end

			// Integrating counter with load, in units of 0.0001.
			always_comb begin
				cnt_next = cnt_reg;
				if (i_cnt_load[ch]) begin
					cnt_next = i_cnt_load_val[ch*48 +: 48];
				end else if (din_rise[ch] && !i_in_sync_mode[ch] && ch_en) begin
					cnt_next = cnt_reg + 48'(i_in_weight[ch*24 +: 24]);
				end
			end

			// Analog slope, clamp and timed hold.
			always_comb begin
				omin = i_ana_out_min[ch*16 +: 16];
				omax = i_ana_out_max[ch*16 +: 16];
				hval = i_ana_hold_val[ch*16 +: 16];
				prod = 32'(i_ana_var[ch*16 +: 16] - i_ana_in_min[ch*16 +: 16])
					* 32'(i_ana_gain[ch*16 +: 16]);
				lin = 25'(omin) + 25'(prod[31:8]);
				hold_next = hold_reg;
				hold_val_next = hold_val_reg;
				hold_cnt_next = hold_cnt_reg;
				if (i_ana_hold_cmd[ch]) begin
					hold_next = 1'b1;
					hold_cnt_next = 20'(HOLD_TIMEOUT_MS - 1);
					hold_val_next = (hval < omin) ? omin : ((hval > omax) ? omax : hval);
				end else if (hold_reg && ms_tick) begin
					if (hold_cnt_reg == 20'h0) begin
						hold_next = 1'b0;
					end else begin
						hold_cnt_next = hold_cnt_reg - 20'h1;
					end
				end
				if (hold_reg) begin
					ana_next = hold_val_reg;
				end else if (i_ana_var[ch*16 +: 16] <= i_ana_in_min[ch*16 +: 16]) begin
					ana_next = omin;
				end else if (lin >= 25'(omax)) begin
					ana_next = omax;
				end else begin
					ana_next = lin[15:0];
				end
			end

			// Register every group of channel state.
			always_ff @(posedge i_ref_clk or negedge rstn) begin
				if (!rstn) begin
					acc_reg <= 17'h0;
					pend_reg <= 8'h0;
					ps_reg <= PS_IDLE;
					pw_cnt_reg <= 9'h0;
					lag_cnt_reg <= 16'h0;
					alarm_reg <= 1'b0;
					force_reg <= 1'b0;
					force_lvl_reg <= 1'b0;
					force_cnt_reg <= 20'h0;
					relay_reg <= 1'b0;
					cnt_reg <= COUNT_RESET;
					hold_reg <= 1'b0;
					hold_val_reg <= 16'h0;
					hold_cnt_reg <= 20'h0;
					ana_reg <= 16'h0;
				end else if (i_ce) begin
					acc_reg <= acc_next;
					pend_reg <= pend_next;
					ps_reg <= ps_next;
					pw_cnt_reg <= pw_cnt_next;
					lag_cnt_reg <= lag_cnt_next;
					alarm_reg <= alarm_next;
					force_reg <= force_next;
					force_lvl_reg <= force_lvl_next;
					force_cnt_reg <= force_cnt_next;
					relay_reg <= relay_next;
					cnt_reg <= cnt_next;
					hold_reg <= hold_next;
					hold_val_reg <= hold_val_next;
					hold_cnt_reg <= hold_cnt_next;
					ana_reg <= ana_next;
				end
			end

			assign o_relay_close[ch] = relay_reg;
			assign o_force_active[ch] = force_reg;
			assign o_alarm_active[ch] = alarm_reg;
			assign o_in_count[ch*48 +: 48] = cnt_reg;
			assign o_ana_out[ch*16 +: 16] = ana_reg;
			assign o_ana_hold_active[ch] = hold_reg;
		end
	endgenerate
endmodule

// ---- inc/io_card_pkg.sv ----
// Shared constants for the option card pulse, alarm and input logic.
package io_card_pkg;
	// Clock and time base.
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
	// Pulse width choices in milliseconds.
	localparam logic [8:0] PW_SHORT_MS = 9'd30;
	localparam logic [8:0] PW_STEP_MS = 9'd50;
	localparam logic [3:0] PW_MAX_CODE = 4'ha;
	// Forced output and analog hold release time.
	localparam int HOLD_TIMEOUT_MIN = 10;
	localparam int HOLD_TIMEOUT_MS_DEF = HOLD_TIMEOUT_MIN * 60 * 1000;
	// Clock synchronisation window.
	localparam logic [11:0] SYNC_WINDOW_S = 12'd5;
	localparam logic [11:0] SEC_PER_HOUR = 12'd3600;
	// Alarm hysteresis band in variable units.
	localparam logic [15:0] ALARM_HYST = 16'h0010;
	// Energy quantities and weights.
	localparam int N_ENERGY = 7;
	localparam logic [2:0] WEIGHT_CODE_MAX = 3'h5;
	// Channel counts and reset values.
	localparam int N_CH = 2;
	localparam logic [7:0] PEND_MAX = 8'hff;
	localparam logic [47:0] COUNT_RESET = 48'h0;
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_ON = 2'b01,
		PS_GAP = 2'b10
	} pulse_state_t;
endpackage

// ---- bench/option_card_io_sva.sv ----
// Port level assertions for the option card logic.
`timescale 1ns/1ns
module option_card_io_sva import io_card_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_net_port_sel,
	input wire logic i_mixed_card,
	input wire logic [N_CH-1:0] i_out_pulse_mode,
	input wire logic [N_CH-1:0] i_force_cmd,
	input wire logic [N_CH-1:0] i_force_level,
	input wire logic [N_CH-1:0] i_din,
	input wire logic [N_CH-1:0] i_alarm_upper,
	input wire logic [N_CH*16-1:0] i_alarm_value,
	input wire logic [N_CH*16-1:0] i_alarm_thr,
	input wire logic [N_CH*16-1:0] i_ana_out_max,
	input wire logic [11:0] i_clk_sec_of_hour,
	input wire logic [N_CH-1:0] o_relay_close,
	input wire logic [N_CH-1:0] o_force_active,
	input wire logic [N_CH-1:0] o_alarm_active,
	input wire logic [N_CH-1:0] o_din_level,
	input wire logic o_clk_round,
	input wire logic o_clk_round_up,
	input wire logic [N_CH*16-1:0] o_ana_out,
	input wire logic o_serial_en,
	input wire logic o_net_en
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	// -----------------------------------------------------------------
	// Forced output takes effect in two steps.
	// -----------------------------------------------------------------
	sequence s_force_taken;
		o_force_active[0] ##1 (o_relay_close[0] == $past(i_force_level[0], 2));
	endsequence
	a_force_level_out: assert property (i_force_cmd[0] |=> s_force_taken)
		else $error("forced level not shown on relay");
	a_port_one_only: assert property (o_net_en == i_net_port_sel && o_serial_en != o_net_en)
		else $error("port enables wrong");
	a_din_level_seen: assert property (i_din[0][*5] |-> o_din_level[0])
		else $error("input level not reported");
	a_round_in_window: assert property (o_clk_round |->
		($past(i_clk_sec_of_hour) < 12'd5 || $past(i_clk_sec_of_hour) > 12'd3595))
		else $error("clock rounded outside window");
	a_round_dir_ok: assert property (o_clk_round |-> o_clk_round_up == ($past(i_clk_sec_of_hour) > 12'd3595))
		else $error("rounding direction wrong");
	a_round_one_cycle: assert property (o_clk_round |=> !o_clk_round)
		else $error("round pulse too long");
	a_ana_max_sat: assert property (o_ana_out[15:0] <= $past(i_ana_out_max[15:0]))
		else $error("analog output above maximum");
	a_alarm_hyst_clear: assert property (o_alarm_active[0] && i_alarm_upper[0] &&
		({1'b0, i_alarm_value[15:0]} + 17'd16 < {1'b0, i_alarm_thr[15:0]}) |=> !o_alarm_active[0])
		else $error("alarm did not clear");
	a_relay_alarm_mode: assert property ($past(!i_out_pulse_mode[0]) && !i_out_pulse_mode[0] &&
		!o_force_active[0] && !$past(o_force_active[0]) && !$past(o_force_active[0], 2)
		|-> o_relay_close[0] == $past(o_alarm_active[0]))
		else $error("relay does not follow alarm");
	a_mixed_ch1_open: assert property (i_mixed_card[*2] |-> !o_relay_close[1])
		else $error("second output used on mixed card");
endmodule
bind option_card_io option_card_io_sva i_chk (.*);

// ---- bench/pulse_partner.sv ----
// Pulse meter on output 0 and pulse sources for both inputs.
`timescale 1ns/1ns
module pulse_partner (
	input wire logic i_clk,
	input wire logic i_relay,
	input wire logic [1:0] i_fire,
	output logic [1:0] o_din,
	output int o_closes,
	output int o_last_w
);
	int run = 0;
	logic [3:0] hold [2] = '{4'h0, 4'h0};
	initial o_closes = 0;
	initial o_last_w = 0;
	// The meter counts a pulse when the contact opens again; sources hold 6 cycles.
	always @(posedge i_clk) begin
		if (i_relay) begin
			run <= run + 1;
		end else if (run != 0) begin
			o_closes <= o_closes + 1;
			o_last_w <= run;
			run <= 0;
		end
		for (int k = 0; k < 2; k++) begin
			if (i_fire[k]) hold[k] <= 4'h6;
			else if (hold[k] != 4'h0) hold[k] <= hold[k] - 4'h1;
		end
	end
	assign o_din = {hold[1] != 4'h0, hold[0] != 4'h0};
endmodule

// ---- bench/option_card_io_tb_top.sv ----
// Self-checking testbench for the option card logic.
`timescale 1ns/1ns
module option_card_io_tb_top import io_card_pkg::*;;
	logic i_ref_clk;
	logic i_rstn = 0, i_ce = 1, i_mixed_card = 0, i_net_port_sel = 0;
	logic [3:0] i_pulse_width_sel = '0;
	logic [6:0] i_energy_tick = '0;
	logic [1:0] i_out_pulse_mode = '0, i_alarm_upper = '0, i_force_cmd = '0, i_force_level = '0;
	logic [1:0] i_in_sync_mode = '0, i_cnt_load = '0, i_ana_hold_cmd = '0, i_din, fire = '0;
	logic [5:0] i_energy_sel = '0, i_weight_code = '0;
	logic [31:0] i_alarm_value = '0, i_alarm_thr = '0, i_alarm_lag_ms = '0, i_ana_var = '0;
	logic [31:0] i_ana_in_min = '0, i_ana_gain = '0, i_ana_out_min = '0, i_ana_out_max = '0;
	logic [31:0] i_ana_hold_val = '0, o_ana_out;
	logic [47:0] i_in_weight = '0;
	logic [95:0] i_cnt_load_val = '0, o_in_count;
	logic [11:0] i_clk_sec_of_hour = '0;
	logic [1:0] o_relay_close, o_force_active, o_alarm_active, o_din_level, o_ana_hold_active;
	logic o_clk_round, o_clk_round_up, o_serial_en, o_net_en;
	int closes, last_w, miscompares = 0, samples_checked = 0;
	option_card_io #(.CYC_PER_MS(4), .HOLD_TIMEOUT_MS(20)) i_option_card_io (.*);
	pulse_partner i_pulse_partner (.i_clk(i_ref_clk), .i_relay(o_relay_close[0]), .i_fire(fire),
		.o_din(i_din), .o_closes(closes), .o_last_w(last_w));
	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	initial begin
		i_ref_clk = 0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	task cy(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task ticks(input logic [6:0] pat, input int k);
		i_energy_tick = pat;
		cy(k);
		i_energy_tick = '0;
	endtask
	task summarize();
		if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task t_ports();
		chk(o_relay_close, 0);
		chk(o_serial_en, 1);
		i_net_port_sel = 1;
		#1 chk({o_serial_en, o_net_en}, 2'b01);
	endtask
	logic [3:0] w4 [3] = '{4'h1, 4'ha, 4'hb};
	task t_pulse();
		int n, w;
		i_mixed_card = 1;
		i_out_pulse_mode = 2'b11;
		i_weight_code = 6'o11;
		n = closes;
		ticks(7'h01, 20);
		cy(600);
		chk(closes - n, 2);
		chk(last_w, 120);
		foreach (w4[j]) begin
			i_pulse_width_sel = w4[j];
			w = (w4[j] > 4'ha) ? 500 : 50 * w4[j];
			ticks(7'h01, 10);
			cy(w * 8 + 20);
			chk(last_w, w * 4);
		end
		i_pulse_width_sel = 0;
		i_weight_code = 6'o12;
		n = closes;
		ticks(7'h02, 100);
		cy(1);
		ticks(7'h01, 99);
		cy(300);
		chk(closes - n, 0);
		ticks(7'h01, 1);
		cy(300);
		chk(closes - n, 1);
		i_out_pulse_mode = 0;
		i_mixed_card = 0;
	endtask
	task t_force();
		i_force_level = 2'b01;
		i_force_cmd = 2'b01;
		cy(1);
		i_force_cmd = 0;
		cy(2);
		chk(o_relay_close[0], 1);
		cy(70);
		chk(o_force_active[0], 1);
		cy(20);
		chk({o_force_active[0], o_relay_close[0]}, 0);
	endtask
	task t_alarm();
		i_alarm_upper = 2'b01;
		i_alarm_thr[15:0] = 100;
		i_alarm_lag_ms[15:0] = 5;
		i_alarm_value[15:0] = 200;
		cy(12);
		chk(o_alarm_active[0], 0);
		cy(30);
		chk({o_alarm_active[0], o_relay_close[0]}, 2'b11);
		i_alarm_value[15:0] = 90;
		cy(3);
		chk(o_alarm_active[0], 1);
		i_alarm_value[15:0] = 80;
		cy(3);
		chk({o_alarm_active[0], o_relay_close[0]}, 0);
		// Lower threshold alarm: 80 is below 100, so the lag starts at once.
		i_alarm_upper = 2'b00;
		cy(42);
		chk(o_alarm_active[0], 1);
		i_alarm_value[15:0] = 110;
		cy(3);
		chk(o_alarm_active[0], 1);
		i_alarm_value[15:0] = 120;
		cy(3);
		chk(o_alarm_active[0], 0);
	endtask
	task t_count();
		i_in_weight[23:0] = 24'd9999999;
		repeat (3) begin
			fire = 2'b01;
			cy(1);
			fire = 0;
			cy(5);
			chk(o_din_level[0], 1);
			cy(15);
		end
		chk(o_in_count[47:0], 48'd29999997);
		i_cnt_load_val[47:0] = 48'h0123456789ab;
		i_cnt_load = 2'b01;
		cy(1);
		i_cnt_load = 0;
		cy(2);
		chk(o_in_count[47:0], 48'h0123456789ab);
		// With the clock enable low a load must not be taken.
		i_ce = 0;
		i_cnt_load_val[47:0] = 48'h1;
		i_cnt_load = 2'b01;
		cy(1);
		i_cnt_load = 0;
		cy(2);
		chk(o_in_count[47:0], 48'h0123456789ab);
		i_ce = 1;
	endtask
	logic [11:0] secs [5] = '{12'd4, 12'd3596, 12'd5, 12'd3595, 12'd100};
	task t_sync();
		logic seen, up;
		i_in_sync_mode = 2'b10;
		foreach (secs[j]) begin
			i_clk_sec_of_hour = secs[j];
			seen = 0;
			up = 0;
			fire = 2'b10;
			cy(1);
			fire = 0;
			repeat (10) begin
				cy(1);
				if (o_clk_round === 1'b1) {seen, up} = {1'b1, o_clk_round_up};
			end
			chk({seen, up}, {j < 2, j == 1});
		end
	endtask
	logic [15:0] vars [3] = '{16'd50, 16'd200, 16'd1000};
	logic [15:0] outs [3] = '{16'd10, 16'd210, 16'd1000};
	task t_analog();
		{i_ana_out_min[15:0], i_ana_out_max[15:0]} = {16'd10, 16'd1000};
		{i_ana_in_min[15:0], i_ana_gain[15:0]} = {16'd100, 16'h0200};
		foreach (vars[j]) begin
			i_ana_var[15:0] = vars[j];
			cy(3);
			chk(o_ana_out[15:0], outs[j]);
		end
		i_ana_var[15:0] = 200;
		i_ana_hold_val[15:0] = 5000;
		i_ana_hold_cmd = 2'b01;
		cy(1);
		i_ana_hold_cmd = 0;
		cy(3);
		chk({o_ana_hold_active[0], o_ana_out[15:0]}, {1'b1, 16'd1000});
		cy(90);
		chk({o_ana_hold_active[0], o_ana_out[15:0]}, {1'b0, 16'd210});
	endtask
	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge i_ref_clk);
		#1 i_rstn = 1;
		cy(4);
		t_ports();
		t_pulse();
		t_force();
		t_alarm();
		t_count();
		t_sync();
		t_analog();
		summarize();
	end
	initial begin
		#1000000;
		miscompares++;
		summarize();
	end
endmodule
